/* cpu_control_register_file.sv */
`timescale 1ns/1ps
module cpu_control_register_file #(
  parameter logic [15:0] ROM_INT_END = cpu_ctrl_pkg::ROM_INT_END
) (
  input wire logic i_clk, // system clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [7:0] i_rf_addr, // register file address
  input wire logic i_rf_word, // word access when high
  input wire logic i_rf_wr, // write strobe
  input wire logic i_rf_rd, // read strobe
  input wire logic [15:0] i_rf_wdata, // write data, low byte for byte
  output logic [15:0] o_rf_rdata, // read data, registered
  output logic o_rf_hit, // address is a control register
  input wire logic [3:0] i_gr_num, // general register number
  input wire logic i_gr_word, // register pair access
  input wire logic i_gr_index, // used as index register
  output logic [7:0] o_gr_ram_addr, // internal ram address
  output logic o_gr_ok, // register usage legal
  input wire logic i_alu_valid, // arithmetic result valid
  input wire logic [7:0] i_alu_a, // operand a
  input wire logic [7:0] i_alu_b, // operand b
  input wire logic i_alu_cin, // use carry in
  input wire logic i_alu_sub, // subtraction
  output logic [7:0] o_alu_res, // arithmetic result
  input wire logic i_bit_valid, // bit instruction done
  input wire logic i_bit_result, // bit instruction outcome
  input wire logic i_ie_set, // enable interrupts
  input wire logic i_ie_clr, // disable interrupts
  input wire logic i_irq_req, // maskable request
  input wire logic [3:0] i_irq_level, // request level
  input wire logic [3:0] i_irq_vector, // vector table index
  output logic o_irq_grant, // request taken, one cycle
  output logic o_busy, // interrupt entry in progress
  output logic o_stk_wr, // stack byte write
  output logic [15:0] o_stk_addr, // stack byte address
  output logic [7:0] o_stk_data, // stack byte data
  input wire logic i_stk_ready, // stack write accepted
  output logic o_vec_rd, // vector fetch request
  output logic [15:0] o_vec_addr, // vector entry address
  input wire logic i_vec_valid, // vector data valid
  input wire logic [15:0] i_vec_data, // handler address
  input wire logic i_sp_push, // core push, predecrement
  input wire logic i_sp_pop, // core pop, postincrement
  input wire logic i_pc_inc, // step program counter
  input wire logic i_pc_load, // load program counter
  input wire logic [15:0] i_pc_value, // new program counter
  output logic [15:0] o_pc, // program counter
  output logic [15:0] o_sp, // stack pointer
  output logic [7:0] o_flags, // flag byte
  output logic o_ext_enable, // expansion mode active
  input wire logic [15:0] i_mem_addr, // address to decode
  input wire logic i_mem_rf_mode, // register file addressing
  output logic o_sel_rf, // register file selected
  output logic o_sel_ram, // ram selected
  output logic o_sel_rom, // internal rom selected
  output logic o_sel_ext, // external memory selected
  output logic o_sel_vec // vector table area
);
  logic [7:0] ps0_r, ps0_nxt;
  logic [7:0] ps1_r, ps1_nxt;
  logic [7:0] sys_r, sys_nxt;
  logic [15:0] sp_r, sp_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [15:0] stk_addr_r, stk_addr_nxt;
  logic [7:0] stk_data_r, stk_data_nxt;
  logic [15:0] vec_addr_r, vec_addr_nxt;
  cpu_ctrl_pkg::irq_state_t st_r, st_nxt;
  logic [7:0] alu_res;
  logic f_c, f_z, f_s, f_v, f_h;
  logic [7:0] ev_addr;
  logic [7:0] wr_hi, wr_lo;

  // stack step; the narrow stack must not carry into the high byte
  function automatic logic [15:0] sp_step(input logic [15:0] sp, input logic wide,
                                          input logic down);
    logic [15:0] full;
    full = down ? sp - 16'h0001 : sp + 16'h0001;
    sp_step = wide ? full : {sp[15:8], full[7:0]};
  endfunction : sp_step

  // highest level accepted for a mask code
  function automatic logic [3:0] mask_limit(input logic [2:0] code);
    logic [3:0] lim;
    lim = cpu_ctrl_pkg::LVL_ALL;
    unique case (code)
      3'h0, 3'h1: lim = cpu_ctrl_pkg::LVL_ALL;
      3'h2: lim = 4'hc;
      3'h3: lim = 4'ha;
      3'h4: lim = 4'h8;
      3'h5: lim = 4'h6;
      3'h6: lim = 4'h4;
      3'h7: lim = 4'h2;
    endcase
    mask_limit = lim;
  endfunction : mask_limit

  // byte view of control registers; zero outside them
  function automatic logic [7:0] ctl_byte(input logic [7:0] a, input logic [7:0] p0,
                                          input logic [7:0] p1, input logic [7:0] sy,
                                          input logic [15:0] sp);
    logic [7:0] v;
    v = 8'h00;
    if (a == cpu_ctrl_pkg::OFS_PS0) v = p0;
    if (a == cpu_ctrl_pkg::OFS_PS1) v = p1;
    if (a == cpu_ctrl_pkg::OFS_SYS) v = sy;
    if (a == cpu_ctrl_pkg::OFS_SPH) v = sp[15:8];
    if (a == cpu_ctrl_pkg::OFS_SPL) v = sp[7:0];
    ctl_byte = v;
  endfunction : ctl_byte

  function automatic logic is_ctl(input logic [7:0] a);
    is_ctl = (a == cpu_ctrl_pkg::OFS_PS0) || (a == cpu_ctrl_pkg::OFS_PS1) ||
             (a == cpu_ctrl_pkg::OFS_SYS) || (a == cpu_ctrl_pkg::OFS_SPH) ||
             (a == cpu_ctrl_pkg::OFS_SPL);
  endfunction : is_ctl

  // flag arithmetic kept apart so the core can share it
  flag_eval u_flag_eval (
    .i_a(i_alu_a),
    .i_b(i_alu_b),
    .i_cin(i_alu_cin & ps1_r[cpu_ctrl_pkg::FLAG_C]),
    .i_sub(i_alu_sub),
    .o_res(alu_res),
    .o_c(f_c),
    .o_z(f_z),
    .o_s(f_s),
    .o_v(f_v),
    .o_h(f_h)
  );

  // word accesses pair the even byte (high) with the odd one (low)
  always_comb begin
    ev_addr = i_rf_word ? {i_rf_addr[7:1], 1'b0} : i_rf_addr;
    wr_hi = i_rf_word ? i_rf_wdata[15:8] : i_rf_wdata[7:0];
    wr_lo = i_rf_wdata[7:0];
  end

  // general register window and usage checks
  always_comb begin
    // window base is pointer times eight
    o_gr_ram_addr = {ps0_r[7:cpu_ctrl_pkg::RP_LSB], 3'h0} + {4'h0, i_gr_num};
    o_gr_ok = 1'b1;
    if (i_gr_index && i_gr_num == 4'h0) o_gr_ok = 1'b0;
    if (!i_gr_word && i_gr_num[3]) o_gr_ok = 1'b0;
    if (i_gr_word && i_gr_num[0]) o_gr_ok = 1'b0;
  end

  // next state of all control registers and the entry sequence
  always_comb begin
    ps0_nxt = ps0_r;
    ps1_nxt = ps1_r;
    sys_nxt = sys_r;
    sp_nxt = sp_r;
    pc_nxt = pc_r;
    rdata_nxt = rdata_r;
    stk_addr_nxt = stk_addr_r;
    stk_data_nxt = stk_data_r;
    vec_addr_nxt = vec_addr_r;
    st_nxt = st_r;
    o_irq_grant = 1'b0;

    // program counter stepping by the core
    if (i_pc_load) begin
      pc_nxt = i_pc_value;
    end else if (i_pc_inc) begin
      pc_nxt = pc_r + 16'h0001;
    end

    if (i_alu_valid) begin
      ps1_nxt[cpu_ctrl_pkg::FLAG_C] = f_c;
      ps1_nxt[cpu_ctrl_pkg::FLAG_Z] = f_z;
      ps1_nxt[cpu_ctrl_pkg::FLAG_S] = f_s;
      ps1_nxt[cpu_ctrl_pkg::FLAG_V] = f_v;
      ps1_nxt[cpu_ctrl_pkg::FLAG_D] = i_alu_sub;
      ps1_nxt[cpu_ctrl_pkg::FLAG_H] = f_h;
    end
    if (i_bit_valid) ps1_nxt[cpu_ctrl_pkg::FLAG_B] = i_bit_result;
    if (i_ie_clr) ps1_nxt[cpu_ctrl_pkg::FLAG_I] = 1'b0;
    if (i_ie_set) ps1_nxt[cpu_ctrl_pkg::FLAG_I] = 1'b1;

    // core stack moves only while no entry sequence runs
    if (st_r == cpu_ctrl_pkg::ST_IDLE) begin
      if (i_sp_push) sp_nxt = sp_step(sp_r, sys_r[cpu_ctrl_pkg::SYS_SPC], 1'b1);
      else if (i_sp_pop) sp_nxt = sp_step(sp_r, sys_r[cpu_ctrl_pkg::SYS_SPC], 1'b0);
    end

    // byte and word access to control registers
    if (i_rf_rd) begin
      if (i_rf_word) begin
        rdata_nxt = {ctl_byte(ev_addr, ps0_r, ps1_r, sys_r, sp_r),
                     ctl_byte(ev_addr | 8'h01, ps0_r, ps1_r, sys_r, sp_r)};
      end else begin
        rdata_nxt = {8'h00, ctl_byte(ev_addr, ps0_r, ps1_r, sys_r, sp_r)};
      end
    end
    // software writes take precedence over same-cycle flag and core stack updates; interrupt entry stack steps override a same-cycle SP write
    if (i_rf_wr) begin
      if (ev_addr == cpu_ctrl_pkg::OFS_PS0) ps0_nxt = wr_hi;
      if (ev_addr == cpu_ctrl_pkg::OFS_PS1) ps1_nxt = wr_hi;
      // spare configuration bits held at zero
      if (ev_addr == cpu_ctrl_pkg::OFS_SYS) sys_nxt = wr_hi & cpu_ctrl_pkg::SYS_WMASK;
      if (ev_addr == cpu_ctrl_pkg::OFS_SPH) sp_nxt[15:8] = wr_hi;
      if (ev_addr == cpu_ctrl_pkg::OFS_SPL) sp_nxt[7:0] = wr_hi;
      if (i_rf_word) begin
        if ((ev_addr | 8'h01) == cpu_ctrl_pkg::OFS_PS1) ps1_nxt = wr_lo;
        if ((ev_addr | 8'h01) == cpu_ctrl_pkg::OFS_SPL) sp_nxt[7:0] = wr_lo;
      end
    end

    // interrupt entry: push pc low, pc high, flags, then fetch vector
    unique case (st_r)
      cpu_ctrl_pkg::ST_IDLE: begin
        if (i_irq_req && ps1_r[cpu_ctrl_pkg::FLAG_I] && i_irq_level != 4'h0 &&
            i_irq_level <= mask_limit(ps0_r[2:0])) begin
          o_irq_grant = 1'b1;
          sp_nxt = sp_step(sp_r, sys_r[cpu_ctrl_pkg::SYS_SPC], 1'b1);
          stk_addr_nxt = sp_nxt;
          stk_data_nxt = pc_r[7:0];
          vec_addr_nxt = cpu_ctrl_pkg::ROM_BASE + {11'h000, i_irq_vector, 1'b0};
          st_nxt = cpu_ctrl_pkg::ST_PCL;
        end
      end
      cpu_ctrl_pkg::ST_PCL: begin
        if (i_stk_ready) begin
          sp_nxt = sp_step(sp_r, sys_r[cpu_ctrl_pkg::SYS_SPC], 1'b1);
          stk_addr_nxt = sp_nxt;
          stk_data_nxt = pc_r[15:8];
          st_nxt = cpu_ctrl_pkg::ST_PCH;
        end
      end
      cpu_ctrl_pkg::ST_PCH: begin
        if (i_stk_ready) begin
          sp_nxt = sp_step(sp_r, sys_r[cpu_ctrl_pkg::SYS_SPC], 1'b1);
          stk_addr_nxt = sp_nxt;
          stk_data_nxt = ps1_r;
          st_nxt = cpu_ctrl_pkg::ST_PSF;
        end
      end
      cpu_ctrl_pkg::ST_PSF: begin
        if (i_stk_ready) st_nxt = cpu_ctrl_pkg::ST_VEC;
      end
      cpu_ctrl_pkg::ST_VEC: begin
        if (i_vec_valid) begin
          pc_nxt = i_vec_data;
          st_nxt = cpu_ctrl_pkg::ST_IDLE;
        end
      end
      default: st_nxt = cpu_ctrl_pkg::ST_IDLE;
    endcase
  end

  // control registers; values during reset are fixed constants
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ps0_r <= cpu_ctrl_pkg::PS0_RST;
      ps1_r <= cpu_ctrl_pkg::PS1_RST;
      sys_r <= cpu_ctrl_pkg::SYS_RST;
      sp_r <= cpu_ctrl_pkg::SP_RST;
      pc_r <= cpu_ctrl_pkg::PC_RESET;
      rdata_r <= 16'h0000;
      stk_addr_r <= 16'h0000;
      stk_data_r <= 8'h00;
      vec_addr_r <= 16'h0000;
      st_r <= cpu_ctrl_pkg::ST_IDLE;
    end else begin
      ps0_r <= ps0_nxt;
      ps1_r <= ps1_nxt;
      sys_r <= sys_nxt;
      sp_r <= sp_nxt;
      pc_r <= pc_nxt;
      rdata_r <= rdata_nxt;
      stk_addr_r <= stk_addr_nxt;
      stk_data_r <= stk_data_nxt;
      vec_addr_r <= vec_addr_nxt;
      st_r <= st_nxt;
    end
  end

  // address space decode; combinational so the core sees it same cycle
  always_comb begin
    o_sel_rf = 1'b0;
    o_sel_ram = 1'b0;
    o_sel_rom = 1'b0;
    o_sel_ext = 1'b0;
    if (i_mem_addr <= cpu_ctrl_pkg::RAM_END) begin
      if (i_mem_addr <= cpu_ctrl_pkg::RF_END && i_mem_rf_mode) o_sel_rf = 1'b1;
      else o_sel_ram = 1'b1;
    end else if (o_ext_enable && i_mem_addr > ROM_INT_END) begin
      o_sel_ext = 1'b1;
    end else begin
      o_sel_rom = 1'b1;
    end
    o_sel_vec = (i_mem_addr >= cpu_ctrl_pkg::ROM_BASE) && (i_mem_addr <= cpu_ctrl_pkg::VEC_END);
  end

  assign o_ext_enable = (sys_r[2:0] == cpu_ctrl_pkg::MCNF_EXP64);
  assign o_rf_hit = is_ctl(i_rf_addr) && (i_rf_addr > 8'h0f);
  assign o_rf_rdata = rdata_r;
  assign o_alu_res = alu_res;
  assign o_busy = (st_r != cpu_ctrl_pkg::ST_IDLE);
  assign o_stk_wr = (st_r == cpu_ctrl_pkg::ST_PCL) || (st_r == cpu_ctrl_pkg::ST_PCH) ||
                    (st_r == cpu_ctrl_pkg::ST_PSF);
  assign o_stk_addr = stk_addr_r;
  assign o_stk_data = stk_data_r;
  assign o_vec_rd = (st_r == cpu_ctrl_pkg::ST_VEC);
  assign o_vec_addr = vec_addr_r;
  assign o_pc = pc_r;
  assign o_sp = sp_r;
  assign o_flags = ps1_r;
endmodule : cpu_control_register_file

/* cpu_ctrl_pkg.sv */
package cpu_ctrl_pkg;
  // program counter start, vector table and memory map bounds
  localparam logic [15:0] PC_RESET = 16'h1020;
  localparam logic [15:0] ROM_BASE = 16'h1000;
  localparam logic [15:0] VEC_END = 16'h101f;
  localparam logic [15:0] RAM_END = 16'h0fff;
  localparam logic [15:0] RF_END = 16'h007f;
  localparam logic [15:0] ROM_INT_END = 16'h1fff;
  // register file offsets of the control registers
  localparam logic [7:0] OFS_SYS = 8'h19;
  localparam logic [7:0] OFS_SPH = 8'h1c;
  localparam logic [7:0] OFS_SPL = 8'h1d;
  localparam logic [7:0] OFS_PS0 = 8'h1e;
  localparam logic [7:0] OFS_PS1 = 8'h1f;
  // reset values
  localparam logic [7:0] PS0_RST = 8'h00;
  localparam logic [7:0] PS1_RST = 8'h00;
  localparam logic [7:0] SYS_RST = 8'h00;
  localparam logic [15:0] SP_RST = 16'h0000;
  // field positions
  localparam int RP_LSB = 3;
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam int FLAG_B = 1;
  localparam int FLAG_I = 0;
  localparam int SYS_SPC = 6;
  localparam logic [7:0] SYS_WMASK = 8'h47;
  localparam logic [2:0] MCNF_OFF = 3'h0;
  localparam logic [2:0] MCNF_EXP64 = 3'h6;
  // highest level accepted for mask codes 0 and 1
  localparam logic [3:0] LVL_ALL = 4'hf;
  // interrupt entry sequence
  typedef enum logic [2:0] {ST_IDLE, ST_PCL, ST_PCH, ST_PSF, ST_VEC} irq_state_t;
endpackage : cpu_ctrl_pkg

/* flag_eval.sv */
`timescale 1ns/1ps
module flag_eval (
  input wire logic [7:0] i_a, // first operand
  input wire logic [7:0] i_b, // second operand
  input wire logic i_cin, // carry or borrow in
  input wire logic i_sub, // subtraction when high
  output logic [7:0] o_res, // result byte
  output logic o_c, // carry out
  output logic o_z, // zero result
  output logic o_s, // negative result
  output logic o_v, // signed overflow
  output logic o_h // carry bit 3 to 4
);
  logic [7:0] b_eff;
  logic [8:0] sum;
  logic [4:0] low;

  // subtraction as add of inverted operand, carry flag holds borrow
  always_comb begin
    b_eff = i_sub ? ~i_b : i_b;
    sum = {1'b0, i_a} + {1'b0, b_eff} + {8'h00, i_cin ^ i_sub};
    low = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, i_cin ^ i_sub};
    o_res = sum[7:0];
    o_c = sum[8] ^ i_sub;
    o_z = (sum[7:0] == 8'h00);
    o_s = sum[7];
    o_v = (i_a[7] == b_eff[7]) && (sum[7] != i_a[7]);
    o_h = low[4] ^ i_sub;
  end
endmodule : flag_eval

/* cpu_ctrl_asserts.sv */
`timescale 1ns/1ps
module cpu_ctrl_asserts (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // reset, low
  input wire logic [3:0] i_gr_num, // reg number
  input wire logic i_gr_word, // pair access
  input wire logic i_gr_index, // index use
  input wire logic o_gr_ok, // usage legal
  input wire logic [15:0] i_mem_addr, // decoded addr
  input wire logic o_sel_ram, // ram select
  input wire logic o_sel_rf, // file select
  input wire logic o_irq_grant, // grant pulse
  input wire logic [3:0] i_irq_level, // req level
  input wire logic [7:0] o_flags, // flag byte
  input wire logic o_busy, // entry running
  input wire logic o_stk_wr, // stack write
  input wire logic i_stk_ready, // stack accept
  input wire logic [15:0] o_stk_addr, // stack addr
  input wire logic o_vec_rd, // vector fetch
  input wire logic [15:0] o_vec_addr, // vector addr
  input wire logic i_vec_valid, // vector data ok
  input wire logic [15:0] i_vec_data, // handler addr
  input wire logic [15:0] o_pc, // program counter
  input wire logic i_alu_valid, // alu strobe
  input wire logic [7:0] o_alu_res, // alu result
  input wire logic i_rf_wr // register write
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // entry steps: grant, then stack writes
  sequence s_take; o_irq_grant; endsequence
  sequence s_push; o_busy && o_stk_wr; endsequence
  property p_grant_ie; o_irq_grant |-> o_flags[0] && i_irq_level != 4'h0; endproperty
  a_grant_ie: assert property (p_grant_ie) else $error("grant while disabled");
  property p_grant_push; s_take |=> s_push; endproperty
  a_grant_push: assert property (p_grant_push) else $error("no push after grant");
  property p_stk_hold; o_stk_wr && !i_stk_ready |=> o_stk_wr && $stable(o_stk_addr); endproperty
  a_stk_hold: assert property (p_stk_hold) else $error("stack write dropped");
  property p_vec_addr; o_vec_rd |-> o_vec_addr[15:5] == 11'h080 && !o_vec_addr[0]; endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector addr off table");
  property p_vec_load; o_vec_rd && i_vec_valid |=> o_pc == $past(i_vec_data) && !o_busy; endproperty
  a_vec_load: assert property (p_vec_load) else $error("pc not loaded");
  property p_gr_index; i_gr_index && i_gr_num == 4'h0 |-> !o_gr_ok; endproperty
  a_gr_index: assert property (p_gr_index) else $error("first reg as index");
  property p_gr_byte; !i_gr_word && i_gr_num[3] |-> !o_gr_ok; endproperty
  a_gr_byte: assert property (p_gr_byte) else $error("upper byte name ok");
  property p_rom_area; i_mem_addr > 16'h0fff |-> !o_sel_ram && !o_sel_rf; endproperty
  a_rom_area: assert property (p_rom_area) else $error("ram above 0fff");
  property p_zero; i_alu_valid && !i_rf_wr |=> o_flags[6] == ($past(o_alu_res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule : cpu_ctrl_asserts

/* tb_cpu_control_register_file.sv */
`timescale 1ns/1ps
module tb_cpu_control_register_file;
  logic i_clk, i_rst_n, i_rf_word, i_rf_wr, i_rf_rd, i_gr_word, i_gr_index, i_alu_valid;
  logic i_alu_cin, i_alu_sub, i_bit_valid, i_bit_result, i_ie_set, i_ie_clr, i_irq_req;
  logic i_stk_ready, i_vec_valid, i_sp_push, i_sp_pop, i_pc_inc, i_pc_load, i_mem_rf_mode;
  logic o_rf_hit, o_gr_ok, o_irq_grant, o_busy, o_stk_wr, o_vec_rd, o_ext_enable;
  logic o_sel_rf, o_sel_ram, o_sel_rom, o_sel_ext, o_sel_vec;
  logic [7:0] i_rf_addr, i_alu_a, i_alu_b, o_gr_ram_addr, o_alu_res, o_stk_data, o_flags;
  logic [3:0] i_gr_num, i_irq_level, i_irq_vector;
  logic [15:0] i_rf_wdata, o_rf_rdata, o_stk_addr, o_vec_addr, i_vec_data, i_pc_value;
  logic [15:0] o_pc, o_sp, i_mem_addr, rd;
  int error_cnt, num_checks;
  cpu_control_register_file cpu_control_register_file_inst (.*);
  always #10 i_clk = ~i_clk;
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask : tick
  // register port: one-cycle strobes, then an idle edge so back-to-back calls never
  // lower and raise a strobe in the same step; read data taken after the edge
  task automatic rf_wr(input logic [7:0] a, input logic w, input logic [15:0] d);
    {i_rf_addr, i_rf_word, i_rf_wdata, i_rf_wr} = {a, w, d, 1'b1};
    tick(1);
    i_rf_wr = 1'b0;
    tick(1);
  endtask : rf_wr
  task automatic rf_rd(input logic [7:0] a, input logic w);
    {i_rf_addr, i_rf_word, i_rf_rd} = {a, w, 1'b1};
    tick(1);
    i_rf_rd = 1'b0;
    rd = o_rf_rdata;
    tick(1);
  endtask : rf_rd
  task automatic t_regs();
    // spare bits written as zero, legal code 110
    rf_wr(cpu_ctrl_pkg::OFS_SYS, 1'b0, 16'h0046);
    rf_rd(cpu_ctrl_pkg::OFS_SYS, 1'b0);
    chk("sys readback", rd, 16'h0046);
    chk("control hit", 16'(o_rf_hit), 16'h0001);
    rf_wr(cpu_ctrl_pkg::OFS_SPH, 1'b1, 16'h0345);
    chk("sp word write", o_sp, 16'h0345);
    rf_wr(cpu_ctrl_pkg::OFS_PS0, 1'b0, 16'h00a5);
    rf_rd(cpu_ctrl_pkg::OFS_PS0, 1'b0);
    chk("status byte", rd, 16'h00a5);
    rf_rd(cpu_ctrl_pkg::OFS_PS0, 1'b1);
    chk("status word", rd, 16'ha500);
    rf_rd(8'h20, 1'b0);
    chk("unmapped data", rd, 16'h0000);
    chk("unmapped hit", 16'(o_rf_hit), 16'h0000);
    $display("done registers");
  endtask : t_regs
  // general register query is combinational
  task automatic gr(input logic [3:0] n, input logic w, input logic x, input logic ok);
    {i_gr_num, i_gr_word, i_gr_index} = {n, w, x};
    tick(1);
    chk("gr ok", 16'(o_gr_ok), 16'(ok));
    chk("gr addr", 16'(o_gr_ram_addr), 16'(8'h28 + 8'(n)));
  endtask : gr
  task automatic t_gr();
    // pointer 5 puts the window at 28
    rf_wr(cpu_ctrl_pkg::OFS_PS0, 1'b0, 16'h0028);
    gr(4'h7, 1'b0, 1'b0, 1'b1);
    gr(4'h0, 1'b0, 1'b1, 1'b0);
    gr(4'h1, 1'b0, 1'b1, 1'b1);
    gr(4'h8, 1'b0, 1'b0, 1'b0);
    gr(4'h2, 1'b1, 1'b1, 1'b1);
    gr(4'h0, 1'b1, 1'b1, 1'b0);
    $display("done general registers");
  endtask : t_gr
  task automatic alu(input logic [7:0] a, b, input logic s, input logic [7:0] r,
                     input logic [5:0] f);
    {i_alu_a, i_alu_b, i_alu_sub, i_alu_valid} = {a, b, s, 1'b1};
    #1;
    chk("alu result", 16'(o_alu_res), 16'(r));
    tick(1);
    i_alu_valid = 1'b0;
    chk("flags c..h", 16'(o_flags[7:2]), 16'(f));
    tick(1);
  endtask : alu
  task automatic t_alu();
    alu(8'h7f, 8'h01, 1'b0, 8'h80, 6'h0d);
    alu(8'h01, 8'h01, 1'b1, 8'h00, 6'h12);
    alu(8'hff, 8'h01, 1'b0, 8'h00, 6'h31);
    alu(8'h80, 8'h01, 1'b1, 8'h7f, 6'h07);
    for (int v = 1; v >= 0; v--) begin
      {i_bit_valid, i_bit_result} = {1'b1, 1'(v)};
      tick(1);
      i_bit_valid = 1'b0;
      chk("bit flag", 16'(o_flags[1]), 16'(v));
      tick(1);
    end
    $display("done flags");
  endtask : t_alu
  task automatic sp_step(input logic push, input logic [15:0] e);
    {i_sp_push, i_sp_pop} = {push, !push};
    tick(1);
    {i_sp_push, i_sp_pop} = 2'b00;
    chk("stack pointer", o_sp, e);
    tick(1);
  endtask : sp_step
  task automatic t_stack();
    rf_wr(cpu_ctrl_pkg::OFS_SYS, 1'b0, 16'h0000);
    rf_wr(cpu_ctrl_pkg::OFS_SPH, 1'b1, 16'h0300);
    // narrow stack wraps inside the low byte
    sp_step(1'b1, 16'h03ff);
    sp_step(1'b0, 16'h0300);
    rf_wr(cpu_ctrl_pkg::OFS_SYS, 1'b0, 16'h0040);
    sp_step(1'b1, 16'h02ff);
    sp_step(1'b0, 16'h0300);
    $display("done stack");
  endtask : t_stack
  task automatic t_mask();
    logic [3:0] lim [8] = '{4'hf, 4'hf, 4'hc, 4'ha, 4'h8, 4'h6, 4'h4, 4'h2};
    {i_stk_ready, i_vec_valid, i_vec_data, i_ie_set} = {2'b11, 16'h2000, 1'b1};
    tick(1);
    i_ie_set = 1'b0;
    chk("enable flag", 16'(o_flags[0]), 16'h0001);
    for (int m = 0; m < 8; m++) begin
      rf_wr(cpu_ctrl_pkg::OFS_PS0, 1'b0, 16'(m));
      // one level above the limit (level 0 for all) stands an edge, never taken
      {i_irq_req, i_irq_level} = {1'b1, lim[m] + 4'h1};
      tick(1);
      chk("masked level", 16'(o_irq_grant), 16'h0000);
      chk("masked busy", 16'(o_busy), 16'h0000);
      i_irq_level = lim[m];
      #1;
      chk("limit level", 16'(o_irq_grant), 16'h0001);
      tick(1);
      i_irq_req = 1'b0;
      for (int k = 0; k < 10 && o_busy; k++) tick(1);
      chk("entry ends", 16'(o_busy), 16'h0000);
    end
    i_ie_clr = 1'b1;
    tick(1);
    {i_ie_clr, i_irq_req, i_irq_level} = {2'b01, 4'h1};
    #1;
    chk("disabled grant", 16'(o_irq_grant), 16'h0000);
    tick(1);
    i_irq_req = 1'b0;
    $display("done mask levels");
  endtask : t_mask
  task automatic t_entry();
    rf_wr(cpu_ctrl_pkg::OFS_PS0, 1'b0, 16'h0000);
    rf_wr(cpu_ctrl_pkg::OFS_PS1, 1'b0, 16'h0081);
    rf_wr(cpu_ctrl_pkg::OFS_SPH, 1'b1, 16'h0200);
    {i_pc_load, i_pc_value, i_stk_ready, i_vec_valid} = {1'b1, 16'h1234, 2'b00};
    tick(1);
    {i_pc_load, i_irq_req, i_irq_level, i_irq_vector} = {2'b01, 4'h3, 4'h3};
    {i_vec_data} = 16'h2468;
    tick(1);
    i_irq_req = 1'b0;
    // stalled stack write must hold its address
    tick(1);
    chk("pc low push", {o_stk_addr[7:0], o_stk_data}, 16'hff34);
    i_stk_ready = 1'b1;
    tick(1);
    chk("pc high push", {o_stk_addr[7:0], o_stk_data}, 16'hfe12);
    tick(1);
    chk("flag push", {o_stk_addr[7:0], o_stk_data}, 16'hfd81);
    tick(1);
    chk("vector addr", o_vec_addr, 16'h1006);
    i_vec_valid = 1'b1;
    tick(1);
    chk("handler pc", o_pc, 16'h2468);
    chk("stack after", o_sp, 16'h01fd);
    i_pc_inc = 1'b1;
    tick(1);
    i_pc_inc = 1'b0;
    chk("pc step", o_pc, 16'h2469);
    $display("done interrupt entry");
  endtask : t_entry
  task automatic t_map();
    // address, file mode, then rf ram rom ext vec
    logic [21:0] tb [9] = '{{16'h0010, 6'h30}, {16'h0010, 6'h08}, {16'h0080, 6'h28},
                            {16'h0fff, 6'h08}, {16'h1000, 6'h05}, {16'h101f, 6'h05},
                            {16'h1020, 6'h04}, {16'h1fff, 6'h04}, {16'h2000, 6'h02}};
    rf_wr(cpu_ctrl_pkg::OFS_SYS, 1'b0, 16'h0000);
    chk("expansion off", 16'(o_ext_enable), 16'h0000);
    rf_wr(cpu_ctrl_pkg::OFS_SYS, 1'b0, 16'h0006);
    chk("expansion on", 16'(o_ext_enable), 16'h0001);
    for (int j = 0; j < 9; j++) begin
      {i_mem_addr, i_mem_rf_mode} = tb[j][21:5];
      tick(1);
      chk("decode", 16'({o_sel_rf, o_sel_ram, o_sel_rom, o_sel_ext, o_sel_vec}),
          16'(tb[j][4:0]));
    end
    $display("done address map");
  endtask : t_map
  task automatic t_reset();
    chk("pc reset", o_pc, 16'h1020);
    chk("sp reset", o_sp, 16'h0000);
    chk("flags reset", 16'(o_flags), 16'h0000);
    $display("done reset");
  endtask : t_reset
  initial begin
    {i_clk, i_rst_n, i_rf_word, i_rf_wr, i_rf_rd, i_gr_word, i_gr_index, i_alu_valid} = '0;
    {i_alu_cin, i_alu_sub, i_bit_valid, i_bit_result, i_ie_set, i_ie_clr, i_irq_req} = '0;
    {i_stk_ready, i_vec_valid, i_sp_push, i_sp_pop, i_pc_inc, i_pc_load, i_mem_rf_mode} = '0;
    {i_rf_addr, i_alu_a, i_alu_b, i_gr_num, i_irq_level, i_irq_vector} = '0;
    {i_rf_wdata, i_vec_data, i_pc_value, i_mem_addr} = '0;
    tick(3);
    i_rst_n = 1'b1;
    t_reset();
    t_regs();
    t_gr();
    t_alu();
    t_stack();
    t_mask();
    t_entry();
    t_map();
    stop_test();
  end
  // hang guard, far beyond the roughly 150 cycles needed
  initial begin
    #100000;
    error_cnt++;
    $display("ERROR watchdog expected end seen hang");
    stop_test();
  end
endmodule : tb_cpu_control_register_file
bind cpu_control_register_file cpu_ctrl_asserts cpu_ctrl_asserts_inst (.*);
